// ### hp_asserts.sv
// Checker of the host port handshake block
`timescale 1ns/10ps
`default_nettype none
module hp_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Pins and core side
  input wire hp_pkg::hp_host_in_s host_in,
  input wire hp_pkg::hp_host_out_s host_out,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic irq_request
);
  import hp_pkg::*;
  // Strobe aliases
  wire logic wn = host_in.host_write_strobe_n;
  wire logic rn = host_in.host_read_strobe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Pin and buffer relations
  AST_IRQ: assert property (host_out.irq_n_oe == irq_request)
    else $error("irq");
  AST_RST: assert property ($rose(nrst) |-> !host_out.tx_dma_request
    && !host_out.rx_dma_request) else $error("req after reset");
  AST_TX_TAKE: assert property ($fell(wn) && !host_in.tx_dma_ack_n
    && ce && !tx_valid |=> tx_valid
    && tx_byte == $past(host_in.host_data_bus)) else $error("tx take");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_byte)) else $error("tx hold");
  AST_TX_DRAIN: assert property (tx_valid && tx_ready && wn && ce
    |=> !tx_valid) else $error("tx drain");
  AST_HIGH_BYTE: assert property ($fell(wn) && host_in.tx_dma_ack_n
    && !host_in.host_select_n && host_in.host_addr_lines == 4'h1
    && !tx_valid |=> !tx_valid) else $error("high byte");
  AST_TX_REQ: assert property (host_out.tx_dma_request |-> !tx_valid)
    else $error("tx req");
  AST_RX_OE: assert property (!rn && !host_in.rx_dma_ack_n
    |-> host_out.host_data_oe) else $error("rx oe");
  AST_OE_ADDR: assert property (!rn && !host_in.host_select_n
    |-> host_out.host_data_oe) else $error("addressed oe");
  AST_OE_IDLE: assert property (rn |-> !host_out.host_data_oe)
    else $error("oe idle");
  AST_RX_POP: assert property ($rose(rn) && !$past(host_in.rx_dma_ack_n)
    && host_out.rx_dma_request && !rx_valid && ce
    |=> !host_out.rx_dma_request) else $error("rx pop");
endmodule
`default_nettype wire

// ### hp_host_model.sv
// Host side model of the DMA controller and processor
`timescale 1ns/10ps
`default_nettype none
module hp_host_model (
  // Clock
  input wire logic clk,
  // Host pins
  output var hp_pkg::hp_host_in_s host_in,
  input wire hp_pkg::hp_host_out_s host_out
);
  import hp_pkg::*;
  // Idle pins, strobes and acks released high
  initial host_in = '{8'h5a, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  // One access; r picks read, dma picks the ack over select
  task automatic acc(input logic r, input logic dma, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    host_in = '{d, a, r, !r, dma, !(dma && !r), !(dma && r)};
    repeat (1 + r) @(posedge clk);
    #1 q = host_out.host_data_out;
    host_in = '{~d, a, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    @(posedge clk) #1;
  endtask
endmodule
`default_nettype wire

// ### hp_host_port.sv
// Host port data buffer handshake with DMA acknowledge and request pins
//
// Contract
// - Transmit ack low plus falling write strobe stores one host byte.
// - Transmit ack selects the transmit port, ignoring address; with select also low it stores no byte.
// - Receive request goes high while the receive buffer holds a byte.
// - Buffers are reachable both by ack cycles and addressed cycles.
// - Receive request enabled by control bit; disabled after reset.
// - Receive ack and read strobe low put the receive byte on the bus.
// - Receive ack selects the receive port, ignoring address; with select also low the byte is not popped.
// - Open-collector interrupt pulled low when requested, released otherwise.
// - Transmit request high when a byte fits; control bit enables it.
// - Address lines 3..1 pick the register, line 0 picks the byte.
`timescale 1ns/10ps
`default_nettype none
module hp_host_port (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Host pins
  input wire hp_pkg::hp_host_in_s host_in,
  output var hp_pkg::hp_host_out_s host_out,
  // Core side: transmit bytes toward the core
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  // Core side: receive bytes from the core
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready,
  // Core interrupt request level
  input wire logic irq_request
);
  import hp_pkg::*;

  // Strobe history
  logic prev_wr_n;
  logic prev_rd_n;
  logic prev_rx_sel;

  // Control and buffer state
  logic [7:0] ctrl;
  logic tx_full;
  logic rx_full;
  logic [7:0] rx_data;
  logic [7:0] data_out;

  // Decoded strobes and selects
  logic wr_fall;
  logic rd_rise;
  logic addr_cycle;
  logic [2:0] idx;
  logic lo_byte;
  logic data_hit;
  logic ack_clash;
  logic tx_sel;
  logic rx_sel;
  logic ctrl_wr;

  // Transfer events
  logic tx_wr;
  logic tx_pop;
  logic rx_pop;
  logic rx_push;

  // Request enables and pin values
  logic tx_req_en;
  logic rx_req_en;
  logic tx_req;
  logic rx_req;
  logic bus_drive;

  // Read data
  logic [7:0] next_data_out;
  logic [7:0] stat;

  // Strobe edges on the sampled pins
  assign wr_fall = prev_wr_n & ~host_in.host_write_strobe_n;
  assign rd_rise = ~prev_rd_n & host_in.host_read_strobe_n;

  // Address decode, only meaningful while select is low
  assign addr_cycle = ~host_in.host_select_n;
  assign idx = host_in.host_addr_lines[3:1];
  assign lo_byte = ~host_in.host_addr_lines[0];

  // Low byte of the data register through an addressed cycle
  assign data_hit = addr_cycle & (idx == HP_IDX_DATA) & lo_byte;

  // Overlapping acks or select are forbidden; such a cycle moves no byte
  assign ack_clash = (~host_in.tx_dma_ack_n & ~host_in.rx_dma_ack_n)
    | (addr_cycle & ~(host_in.tx_dma_ack_n & host_in.rx_dma_ack_n));

  // Port selection: acks bypass the address; a low select with an ack blocks both ports
  assign tx_sel = (~host_in.tx_dma_ack_n | data_hit) & ~ack_clash;
  assign rx_sel = (~host_in.rx_dma_ack_n | data_hit) & ~ack_clash;
  assign ctrl_wr = wr_fall & host_in.tx_dma_ack_n & host_in.rx_dma_ack_n
    & addr_cycle & idx == HP_IDX_CTRL & lo_byte;

  // Transfer events; a pop in the same cycle frees room for a write
  assign tx_pop = tx_full & tx_ready;
  assign tx_wr = wr_fall & tx_sel & (~tx_full | tx_pop);
  assign rx_pop = rd_rise & prev_rx_sel & rx_full;
  assign rx_ready = ~rx_full | rx_pop;
  assign rx_push = rx_valid & rx_ready;
  assign tx_valid = tx_full;

  // Status byte
  always_comb begin
    stat = 8'h00;
    stat[HP_STAT_TX_FULL_BIT] = tx_full;
    stat[HP_STAT_RX_FULL_BIT] = rx_full;
    stat[HP_STAT_IRQ_BIT] = irq_request;
  end

  // Read data mux, registered onto the bus
  always_comb begin
    next_data_out = 8'h00;
    if (~host_in.rx_dma_ack_n) begin
      next_data_out = rx_data;
    end else if (addr_cycle) begin
      case (idx)
        HP_IDX_DATA: next_data_out = lo_byte ? rx_data : 8'h00;
        HP_IDX_CTRL: next_data_out = lo_byte ? ctrl : 8'h00;
        HP_IDX_STAT: next_data_out = lo_byte ? stat : 8'h00;
        default: next_data_out = 8'h00;
      endcase
    end
  end

  // Strobe history for edge detection, idle level after reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_wr_n <= 1'b1;
      prev_rd_n <= 1'b1;
    end else if (ce) begin
      prev_wr_n <= host_in.host_write_strobe_n;
      prev_rd_n <= host_in.host_read_strobe_n;
    end
  end

  // Receive port was read, so the end of the strobe pops it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_rx_sel <= 1'b0;
    end else if (ce) begin
      prev_rx_sel <= rx_sel & ~host_in.host_read_strobe_n;
    end
  end

  // Hardware control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= HP_CTRL_RESET;
    end else if (ce && ctrl_wr) begin
      ctrl <= host_in.host_data_bus;
    end
  end

  // Transmit holding byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_full <= 1'b0;
      tx_byte <= HP_BYTE_RESET;
    end else if (ce) begin
      if (tx_wr) begin
        tx_full <= 1'b1;
        tx_byte <= host_in.host_data_bus;
      end else if (tx_pop) begin
        tx_full <= 1'b0;
      end
    end
  end

  // Receive holding byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_full <= 1'b0;
      rx_data <= HP_BYTE_RESET;
    end else if (ce) begin
      if (rx_push) begin
        rx_full <= 1'b1;
        rx_data <= rx_byte;
      end else if (rx_pop) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Bus data register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_out <= HP_BYTE_RESET;
    end else if (ce) begin
      data_out <= next_data_out;
    end
  end

  // Request enables from the hardware control register
  assign tx_req_en = ctrl[HP_CTRL_TX_EN_BIT];
  assign rx_req_en = ctrl[HP_CTRL_RX_EN_BIT];

  // Requests follow buffer room and content, low while disabled
  assign tx_req = tx_req_en & ~tx_full;
  assign rx_req = rx_req_en & rx_full;

  // Bus drive while a read strobe meets the receive ack or the select
  assign bus_drive = ~host_in.host_read_strobe_n
    & (~host_in.rx_dma_ack_n | addr_cycle);

  // Pin drive: bus enable, requests gated by enables, open-collector irq
  always_comb begin
    host_out.host_data_out = data_out;
    host_out.host_data_oe = bus_drive;
    host_out.tx_dma_request = tx_req;
    host_out.rx_dma_request = rx_req;
    host_out.irq_n_out = 1'b0;
    host_out.irq_n_oe = irq_request;
  end
endmodule
`default_nettype wire

// ### hp_host_port_tb_top.sv
// Testbench top of the host port handshake block
`timescale 1ns/10ps
`default_nettype none
module hp_host_port_tb_top;
  import hp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic tx_ready = 1'b0;
  logic rx_valid = 1'b0;
  logic irq_request = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] d, e, q;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  hp_host_in_s host_in;
  hp_host_out_s host_out;
  wire logic [7:0] tx_byte;
  wire logic tx_valid;
  wire logic rx_ready;
  hp_host_port i_dut (.clk, .nrst, .ce, .host_in, .host_out,
    .tx_byte, .tx_valid, .tx_ready, .rx_byte, .rx_valid, .rx_ready,
    .irq_request);
  hp_host_model i_host (.clk, .host_in, .host_out);
  // Clock and watchdog
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected status byte from the package field positions
  function automatic logic [7:0] exp_stat(input logic txf, input logic rxf,
      input logic irq);
    exp_stat = 8'h00;
    exp_stat[HP_STAT_TX_FULL_BIT] = txf;
    exp_stat[HP_STAT_RX_FULL_BIT] = rxf;
    exp_stat[HP_STAT_IRQ_BIT] = irq;
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Core side drain and push
  task automatic drain;
    @(posedge clk) #1 tx_ready = 1'b1;
    @(posedge clk) #1 tx_ready = 1'b0;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk) #1 {rx_byte, rx_valid} = {b, 1'b1};
    @(posedge clk) #1 rx_valid = 1'b0;
  endtask
  // Main sequence
  initial begin
    void'($urandom(63));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    chk(host_out.tx_dma_request, 0);
    chk(host_out.rx_dma_request, 0);
    i_host.acc(0, 0, 4'h2, 8'h03, q);
    i_host.acc(1, 0, 4'h2, 8'h00, q);
    chk(q, 8'h03);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      e = 8'($urandom);
      irq_request = 1'($urandom);
      if (e == d) begin
        e = ~d;
      end
      chk(host_out.tx_dma_request, 1);
      chk(host_out.host_data_oe, 0);
      i_host.acc(0, 1, d[3:0], d, q);
      i_host.acc(0, 1, 4'h0, e, q);
      chk(tx_byte, d);
      chk(host_out.tx_dma_request, 0);
      drain();
      i_host.acc(0, 0, 4'h1, e, q);
      chk(tx_valid, 0);
      i_host.acc(0, 0, 4'h0, e, q);
      chk(tx_byte, e);
      drain();
      push(d);
      chk(host_out.rx_dma_request, 1);
      chk(rx_ready, 0);
      i_host.acc(1, 0, 4'h4, e, q);
      chk(q, exp_stat(1'b0, 1'b1, irq_request));
      i_host.acc(1, i[0], {i[0], 3'h0}, e, q);
      chk(q, d);
      chk(host_out.rx_dma_request, 0);
      chk(rx_ready, 1);
      chk(host_out.irq_n_oe, irq_request);
      chk(host_out.irq_n_out, 0);
    end
    // Frozen clock enable: a write strobe moves nothing
    ce = 1'b0;
    i_host.acc(0, 1, 4'h0, 8'ha5, q);
    chk(tx_valid, 0);
    chk(host_out.tx_dma_request, 1);
    ce = 1'b1;
    i_host.acc(0, 0, 4'h2, 8'h01, q);
    push(8'h3c);
    chk(host_out.rx_dma_request, 0);
    // Mid-run reset turns the enabled transmit request off again
    chk(host_out.tx_dma_request, 1);
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    chk(host_out.tx_dma_request, 0);
    chk(rx_ready, 1);
    complete_run();
  end
endmodule
bind hp_host_port hp_asserts i_chk (.clk, .nrst, .ce, .host_in, .host_out,
  .tx_byte, .tx_valid, .tx_ready, .rx_valid, .irq_request);
`default_nettype wire

// ### hp_pkg.sv
// Package for the host port buffer handshake block
package hp_pkg;
  // Host interface register indices, decoded from the upper address lines
  localparam logic [2:0] HP_IDX_DATA = 3'h0;
  localparam logic [2:0] HP_IDX_CTRL = 3'h1;
  localparam logic [2:0] HP_IDX_STAT = 3'h2;
  // Hardware control register field positions (low byte)
  localparam int HP_CTRL_TX_EN_BIT = 0;
  localparam int HP_CTRL_RX_EN_BIT = 1;
  // Status register field positions (low byte)
  localparam int HP_STAT_TX_FULL_BIT = 0;
  localparam int HP_STAT_RX_FULL_BIT = 1;
  localparam int HP_STAT_IRQ_BIT = 2;
  // Reset values
  localparam logic [7:0] HP_CTRL_RESET = 8'h00;
  localparam logic [7:0] HP_BYTE_RESET = 8'h00;

  // Host pins as sampled by the device
  typedef struct packed {
    logic [7:0] host_data_bus;
    logic [3:0] host_addr_lines;
    logic host_write_strobe_n;
    logic host_read_strobe_n;
    logic host_select_n;
    logic tx_dma_ack_n;
    logic rx_dma_ack_n;
  } hp_host_in_s;

  // Host pins driven by the device
  typedef struct packed {
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic tx_dma_request;
    logic rx_dma_request;
    logic irq_n_out;
    logic irq_n_oe;
  } hp_host_out_s;
endpackage
